// [src/ptcsm_consts.vh]
/*
  constants for the protocol timer / csma configuration bank: register
  addresses, reset values, field positions, write masks and timing.
  assumes it is included by bare name from the design files only.
*/
`ifndef PTCSM_CONSTS_VH
`define PTCSM_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PTCSM_ADDR_PROT_HI 8'h51
`define PTCSM_ADDR_PROT_LO 8'h52
`define PTCSM_ADDR_RXTO_PRE 8'h53
`define PTCSM_ADDR_RXTO_CNT 8'h54
`define PTCSM_ADDR_WAKE_PRE 8'h55
`define PTCSM_ADDR_WAKE_CNT 8'h56
`define PTCSM_ADDR_RLD_PRE 8'h57
`define PTCSM_ADDR_RLD_CNT 8'h58
`define PTCSM_ADDR_SEED_HI 8'h64
`define PTCSM_ADDR_SEED_LO 8'h65
`define PTCSM_ADDR_BU_CCA 8'h66
`define PTCSM_ADDR_LISTEN 8'h67

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTCSM_RST_PROT_HI 8'h00
`define PTCSM_RST_PROT_LO 8'h08
`define PTCSM_RST_PRE 8'h01
`define PTCSM_RST_CNT 8'h00
`define PTCSM_RST_SEED_HI 8'hFF
`define PTCSM_RST_SEED_LO 8'h00
`define PTCSM_RST_BU_CCA 8'h04
`define PTCSM_RST_LISTEN 8'h00

// ----------------------------------------------------------------
// write masks (reserved bits stay zero)
// ----------------------------------------------------------------
`define PTCSM_WMASK_PROT_HI 8'hCF
`define PTCSM_WMASK_LISTEN 8'hF7

// ----------------------------------------------------------------
// field positions inside the 8-bit registers
// ----------------------------------------------------------------
`define PTCSM_HI_RELOAD_SYNC 7
`define PTCSM_HI_ACK_CARRY 6
`define PTCSM_HI_SEED_RELOAD 3
`define PTCSM_HI_CSMA_EN 2
`define PTCSM_HI_CSMA_PERS 1
`define PTCSM_HI_AUTO_FILT 0
`define PTCSM_LO_RETX_MSB 7
`define PTCSM_LO_RETX_LSB 4
`define PTCSM_LO_NO_ACK 3
`define PTCSM_BU_PRE_MSB 7
`define PTCSM_BU_PRE_LSB 2
`define PTCSM_CCA_MSB 1
`define PTCSM_CCA_LSB 0
`define PTCSM_LEN_MSB 7
`define PTCSM_LEN_LSB 4
`define PTCSM_NBO_MSB 2
`define PTCSM_NBO_LSB 0

// ----------------------------------------------------------------
// clear-channel assessment lengths in bit periods
// ----------------------------------------------------------------
`define PTCSM_CCA_BITS_0 10'h040
`define PTCSM_CCA_BITS_1 10'h080
`define PTCSM_CCA_BITS_2 10'h100
`define PTCSM_CCA_BITS_3 10'h200

// ----------------------------------------------------------------
// serial port header codes
// ----------------------------------------------------------------
`define PTCSM_HDR_WRITE 8'h00
`define PTCSM_HDR_READ 8'h01

// ----------------------------------------------------------------
// timing: timer base period and clock period, both in ns
// ----------------------------------------------------------------
`define PTCSM_TBASE_NS 1000
`define PTCSM_CLK_NS 100
`define PTCSM_TBASE_CYC (`PTCSM_TBASE_NS / `PTCSM_CLK_NS)

// ----------------------------------------------------------------
// back-off generator feedback taps
// ----------------------------------------------------------------
`define PTCSM_LFSR_TAPS 16'hB400

`endif

// [src/ptcsm_timer.v]
/*
  prescaler-times-counter timer: period is prescale * count base ticks.
  assumes tick is a one-cycle enable from a divider in the parent, and
  that start, stop are one-cycle pulses or levels in the ref_clk domain.
*/
`timescale 1ns/10ps

module ptcsm_timer (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // control
  input wire tick,
  input wire start,
  input wire stop,
  input wire [7:0] prescale,
  input wire [7:0] count,
  // status
  output reg running,
  output reg expire
);

  reg [7:0] preLoad; // prescale captured at start
  reg [7:0] preCnt;  // ticks left in the current prescale step
  reg [7:0] cntLeft; // prescale steps left

  // ----------------------------------------------------------------
  // countdown; start wins over stop so a reload is never lost
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rstn) begin
      running <= 1'b0;
      expire <= 1'b0;
      preLoad <= 8'h00;
      preCnt <= 8'h00;
      cntLeft <= 8'h00;
    end else begin
      expire <= 1'b0;
      if (start) begin
        // zero in either field leaves the timer disabled
        running <= (prescale != 8'h00) && (count != 8'h00);
        preLoad <= prescale;
        preCnt <= prescale;
        cntLeft <= count;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (preCnt == 8'h01) begin
          preCnt <= preLoad;
          if (cntLeft == 8'h01) begin
            running <= 1'b0; // last step: one expiry pulse
            expire <= 1'b1;
          end else begin
            cntLeft <= cntLeft - 8'h01;
          end
        end else begin
          preCnt <= preCnt - 8'h01;
        end
      end
    end
  end

endmodule // ptcsm_timer

// [src/ptcsm_lfsr.v]
/*
  16-bit galois pseudo-random generator for back-off slot choice.
  assumes load and step are one-cycle pulses in the ref_clk domain;
  an all-zero seed locks the generator at zero, software must avoid it.
*/
`timescale 1ns/10ps

`include "ptcsm_consts.vh"

module ptcsm_lfsr (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // control
  input wire load,
  input wire [15:0] seed,
  input wire step,
  // state
  output reg [15:0] value
);

  // ----------------------------------------------------------------
  // shift right, feed taps back; load has priority over a step
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rstn) begin
      value <= {`PTCSM_RST_SEED_HI, `PTCSM_RST_SEED_LO};
    end else if (load) begin
      value <= seed;
    end else if (step) begin
      if (value[0]) begin
        value <= {1'b0, value[15:1]} ^ `PTCSM_LFSR_TAPS;
      end else begin
        value <= {1'b0, value[15:1]};
      end
    end
  end

endmodule // ptcsm_lfsr

// [src/ptcsm_regbank.v]
/*
  protocol timer and csma configuration bank with its serial port,
  receive-timeout and wake-up timers and the back-off seed generator.
  assumes serial port pins are synchronous to ref_clk and that the
  port clock runs slower than a quarter of ref_clk; protocol events
  arrive as one-cycle pulses from the surrounding engine.
*/
`timescale 1ns/10ps

`include "ptcsm_consts.vh"

module ptcsm_regbank (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // serial configuration port
  input wire spiCsN,
  input wire spiSclk,
  input wire spiMosi,
  output reg spiMiso,
  output reg spiMisoOe,
  // protocol engine events
  input wire syncDetected,
  input wire wakeTimerReloadCommand,
  input wire rxStart,
  input wire rxEnd,
  input wire sleepStart,
  input wire sleepEnd,
  input wire backoffStep,
  // quality indicators and their qualification settings
  input wire carrierSense,
  input wire syncQualityIndicator,
  input wire preambleQualityIndicator,
  input wire carrierSenseMask,
  input wire syncQualityMask,
  input wire preambleQualityMask,
  input wire qualityOrSelect,
  // protocol settings
  output wire sleepReloadOnSyncWord,
  output wire ackPayloadCarry,
  output wire carrierSenseAccessEnable,
  output wire carrierSensePersistent,
  output wire autoFilterEnable,
  output wire [3:0] maxRetransmissions,
  output wire noAckRequest,
  // csma settings
  output wire [5:0] backoffUnitPrescale,
  output reg [9:0] ccaBitPeriods,
  output wire [3:0] listenLength,
  output wire [2:0] maxBackoffCycles,
  output wire [15:0] backoffRandom,
  // timers
  output wire rxTimeoutRunning,
  output wire rxTimeoutExpire,
  output wire wakeTimerRunning,
  output wire wakeTimerExpire
);

  // ----------------------------------------------------------------
  // serial port phases
  // ----------------------------------------------------------------
  localparam [2:0] PH_HEAD = 3'h1; // header byte
  localparam [2:0] PH_ADDR = 3'h2; // address byte
  localparam [2:0] PH_DATA = 3'h4; // data bytes, auto-increment

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [7:0] protHi;   // protocol_ctrl_high
  reg [7:0] protLo;   // protocol_ctrl_low
  reg [7:0] rxtoPre;  // rx_timeout_prescale
  reg [7:0] rxtoCnt;  // rx_timeout_count
  reg [7:0] wakePre;  // wake_timer_prescale
  reg [7:0] wakeCnt;  // wake_timer_count
  reg [7:0] rldPre;   // wake_reload_prescale
  reg [7:0] rldCnt;   // wake_reload_count
  reg [7:0] seedHi;   // backoff_seed_high
  reg [7:0] seedLo;   // backoff_seed_low
  reg [7:0] buCca;    // backoff_prescale_cca_period
  reg [7:0] listen;   // listen_length_backoff_max

  // serial port state
  reg [2:0] phase;      // one-hot phase
  reg sclkPrev;         // last port clock level, for edges
  reg [2:0] bitCnt;     // bits taken in current byte
  reg [6:0] shiftIn;    // bits taken so far
  reg [7:0] shiftOut;   // read data on its way out
  reg isRead;           // header asked for a read
  reg [7:0] addr;       // current register address
  reg wrEn;             // one-cycle write strobe
  reg [7:0] wrAddr, wrData; // address and data of that write
  reg [7:0] rdData;     // combinational readback

  // divider and derived strobes
  reg [7:0] tickCnt;    // timer base divider
  reg tick;             // one-cycle timer base enable
  reg seedLoad;         // seed reload strobe
  reg [9:0] next_ccaBitPeriods;

  wire sclkRise, sclkFall, byteDone; // port clock edges, last bit in
  wire [7:0] byteIn; // byte as completed by this bit
  wire wakeReload, wakeStart; // wake timer start causes
  wire [7:0] wakeStartPre, wakeStartCnt; // values taken at start
  wire [2:0] qualMask, qualInd; // masks and indicators
  wire qualStop; // masked stop condition

  assign sclkRise = spiSclk && !sclkPrev;
  assign sclkFall = !spiSclk && sclkPrev;
  assign byteIn = {shiftIn, spiMosi};
  assign byteDone = sclkRise && (bitCnt == 3'h7);

  // ----------------------------------------------------------------
  // setting outputs straight from the register flops
  // ----------------------------------------------------------------
  assign sleepReloadOnSyncWord = protHi[`PTCSM_HI_RELOAD_SYNC];
  assign ackPayloadCarry = protHi[`PTCSM_HI_ACK_CARRY];
  assign carrierSenseAccessEnable = protHi[`PTCSM_HI_CSMA_EN];
  assign carrierSensePersistent = protHi[`PTCSM_HI_CSMA_PERS];
  assign autoFilterEnable = protHi[`PTCSM_HI_AUTO_FILT];
  // engine treats zero as no retransmission at all
  assign maxRetransmissions =
    protLo[`PTCSM_LO_RETX_MSB:`PTCSM_LO_RETX_LSB];
  assign noAckRequest = protLo[`PTCSM_LO_NO_ACK];
  assign backoffUnitPrescale =
    buCca[`PTCSM_BU_PRE_MSB:`PTCSM_BU_PRE_LSB];
  assign listenLength = listen[`PTCSM_LEN_MSB:`PTCSM_LEN_LSB];
  assign maxBackoffCycles = listen[`PTCSM_NBO_MSB:`PTCSM_NBO_LSB];

  // ----------------------------------------------------------------
  // serial port: mode 0, sample on rise, shift out on fall
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rstn) begin
      phase <= PH_HEAD;
      sclkPrev <= 1'b0;
      bitCnt <= 3'h0;
      shiftIn <= 7'h00;
      shiftOut <= 8'h00;
      isRead <= 1'b0;
      addr <= 8'h00;
      wrEn <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
      spiMiso <= 1'b0;
      spiMisoOe <= 1'b0;
    end else begin
      wrEn <= 1'b0;
      sclkPrev <= spiSclk;
      spiMisoOe <= !spiCsN; // drive only while selected
      if (spiCsN) begin
        // deselect aborts any partial byte
        phase <= PH_HEAD;
        bitCnt <= 3'h0;
        shiftOut <= 8'h00;
        spiMiso <= 1'b0;
      end else begin
        if (sclkRise) begin
          shiftIn <= byteIn[6:0];
          bitCnt <= bitCnt + 3'h1;
        end
        if (sclkFall) begin
          // next bit out; byte loaded below lands msb first
          spiMiso <= shiftOut[7];
          shiftOut <= {shiftOut[6:0], 1'b0};
        end
        if (byteDone) begin
          case (phase)
            PH_HEAD: begin
              isRead <= (byteIn == `PTCSM_HDR_READ);
              phase <= PH_ADDR;
            end
            PH_ADDR: begin
              addr <= byteIn;
              phase <= PH_DATA;
            end
            PH_DATA: begin
              // any header but the read code writes
              wrEn <= !isRead;
              wrAddr <= addr;
              wrData <= byteIn;
              addr <= addr + 8'h01;
            end
            default: begin
              phase <= PH_HEAD;
            end
          endcase
        end
        // load readback on the first port clock fall after the address is known
        if (sclkFall && phase == PH_DATA && bitCnt == 3'h0 && isRead) begin
          spiMiso <= rdData[7];
          shiftOut <= {rdData[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // readback mux; unmapped addresses read zero
  // ----------------------------------------------------------------
  always @* begin
    rdData = 8'h00;
    case (addr)
      `PTCSM_ADDR_PROT_HI: rdData = protHi;
      `PTCSM_ADDR_PROT_LO: rdData = protLo;
      `PTCSM_ADDR_RXTO_PRE: rdData = rxtoPre;
      `PTCSM_ADDR_RXTO_CNT: rdData = rxtoCnt;
      `PTCSM_ADDR_WAKE_PRE: rdData = wakePre;
      `PTCSM_ADDR_WAKE_CNT: rdData = wakeCnt;
      `PTCSM_ADDR_RLD_PRE: rdData = rldPre;
      `PTCSM_ADDR_RLD_CNT: rdData = rldCnt;
      `PTCSM_ADDR_SEED_HI: rdData = seedHi;
      `PTCSM_ADDR_SEED_LO: rdData = seedLo;
      `PTCSM_ADDR_BU_CCA: rdData = buCca;
      `PTCSM_ADDR_LISTEN: rdData = listen;
      default: rdData = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // register writes; reserved bits are masked off and stay zero
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rstn) begin
      protHi <= `PTCSM_RST_PROT_HI;
      protLo <= `PTCSM_RST_PROT_LO;
      rxtoPre <= `PTCSM_RST_PRE;
      rxtoCnt <= `PTCSM_RST_CNT;
      wakePre <= `PTCSM_RST_PRE;
      wakeCnt <= `PTCSM_RST_CNT;
      rldPre <= `PTCSM_RST_PRE;
      rldCnt <= `PTCSM_RST_CNT;
      seedHi <= `PTCSM_RST_SEED_HI;
      seedLo <= `PTCSM_RST_SEED_LO;
      buCca <= `PTCSM_RST_BU_CCA;
      listen <= `PTCSM_RST_LISTEN;
      seedLoad <= 1'b0;
    end else begin
      seedLoad <= 1'b0;
      if (wrEn) begin
        case (wrAddr)
          `PTCSM_ADDR_PROT_HI: begin
            protHi <= wrData & `PTCSM_WMASK_PROT_HI;
            // seed taken once per write that carries the bit
            seedLoad <= wrData[`PTCSM_HI_SEED_RELOAD];
          end
          `PTCSM_ADDR_PROT_LO: protLo <= wrData;
          `PTCSM_ADDR_RXTO_PRE: rxtoPre <= wrData;
          `PTCSM_ADDR_RXTO_CNT: rxtoCnt <= wrData;
          `PTCSM_ADDR_WAKE_PRE: wakePre <= wrData;
          `PTCSM_ADDR_WAKE_CNT: wakeCnt <= wrData;
          `PTCSM_ADDR_RLD_PRE: rldPre <= wrData;
          `PTCSM_ADDR_RLD_CNT: rldCnt <= wrData;
          `PTCSM_ADDR_SEED_HI: seedHi <= wrData;
          `PTCSM_ADDR_SEED_LO: seedLo <= wrData;
          `PTCSM_ADDR_BU_CCA: buCca <= wrData;
          `PTCSM_ADDR_LISTEN: listen <= wrData & `PTCSM_WMASK_LISTEN;
          default: begin
            // unmapped: write ignored
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // cca length decode, registered so the output is a flop
  // ----------------------------------------------------------------
  always @* begin
    next_ccaBitPeriods = `PTCSM_CCA_BITS_0;
    case (buCca[`PTCSM_CCA_MSB:`PTCSM_CCA_LSB])
      2'h0: next_ccaBitPeriods = `PTCSM_CCA_BITS_0;
      2'h1: next_ccaBitPeriods = `PTCSM_CCA_BITS_1;
      2'h2: next_ccaBitPeriods = `PTCSM_CCA_BITS_2;
      2'h3: next_ccaBitPeriods = `PTCSM_CCA_BITS_3;
      default: next_ccaBitPeriods = `PTCSM_CCA_BITS_0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rstn)
      ccaBitPeriods <= `PTCSM_CCA_BITS_0;
    else
      ccaBitPeriods <= next_ccaBitPeriods;
  end

  // ----------------------------------------------------------------
  // timer base divider: one tick per base period
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rstn) begin
      tickCnt <= 8'h00;
      tick <= 1'b0;
    end else if ({24'h000000, tickCnt} == `PTCSM_TBASE_CYC - 1) begin
      tickCnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // rx timeout qualification by masked indicators
  // ----------------------------------------------------------------
  assign qualMask = {carrierSenseMask, syncQualityMask,
                     preambleQualityMask};
  assign qualInd = {carrierSense, syncQualityIndicator,
                    preambleQualityIndicator};
  // no mask bit set means no indicator may stop the timeout
  assign qualStop = (qualMask != 3'h0) &&
    (qualityOrSelect ? ((qualMask & qualInd) != 3'h0)
                     : ((qualInd | ~qualMask) == 3'h7));

  ptcsm_timer u_rxTimeout (
    .ref_clk(ref_clk), .rstn(rstn), .tick(tick),
    .start(rxStart), .stop(rxEnd || qualStop),
    .prescale(rxtoPre), .count(rxtoCnt),
    .running(rxTimeoutRunning), .expire(rxTimeoutExpire)
  );

  // ----------------------------------------------------------------
  // wake timer: normal values on sleep entry, reload values otherwise
  // ----------------------------------------------------------------
  assign wakeReload = wakeTimerReloadCommand ||
    (syncDetected && protHi[`PTCSM_HI_RELOAD_SYNC]);
  assign wakeStart = sleepStart || wakeReload;
  // reload wins over a sleep entry in the same cycle
  assign wakeStartPre = wakeReload ? rldPre : wakePre;
  assign wakeStartCnt = wakeReload ? rldCnt : wakeCnt;

  ptcsm_timer u_wakeTimer (
    .ref_clk(ref_clk), .rstn(rstn), .tick(tick),
    .start(wakeStart), .stop(sleepEnd),
    .prescale(wakeStartPre), .count(wakeStartCnt),
    .running(wakeTimerRunning), .expire(wakeTimerExpire)
  );

  // ----------------------------------------------------------------
  // back-off random generator
  // ----------------------------------------------------------------
  ptcsm_lfsr u_backoffRandom (
    .ref_clk(ref_clk), .rstn(rstn), .load(seedLoad),
    .seed({seedHi, seedLo}), .step(backoffStep),
    .value(backoffRandom)
  );

endmodule // ptcsm_regbank

// [sim/ptcsm_monitor.sv]
/* port assertions for the protocol timer and csma bank.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module ptcsm_monitor (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // serial port select and miso enable
  input wire spiCsN,
  input wire spiMisoOe,
  // protocol events and qualifiers
  input wire rxStart,
  input wire rxEnd,
  input wire sleepStart,
  input wire sleepEnd,
  input wire syncDetected,
  input wire wakeTimerReloadCommand,
  input wire backoffStep,
  input wire carrierSense,
  input wire carrierSenseMask,
  input wire qualityOrSelect,
  // outputs watched
  input wire noAckRequest,
  input wire [3:0] maxRetransmissions,
  input wire [15:0] backoffRandom,
  input wire [9:0] ccaBitPeriods,
  input wire rxTimeoutRunning,
  input wire rxTimeoutExpire,
  input wire wakeTimerRunning,
  input wire wakeTimerExpire
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // expiry only out of a running timer, one cycle long
  sequence s_rxPulse;
    $past(rxTimeoutRunning) && rxTimeoutExpire ##1 !rxTimeoutExpire;
  endsequence
  sequence s_wakePulse;
    $past(wakeTimerRunning) && wakeTimerExpire ##1 !wakeTimerExpire;
  endsequence
  property p_rxPulse;
    rxTimeoutExpire |-> s_rxPulse;
  endproperty
  a_rxPulse: assert property (p_rxPulse)
    else $error("rx expiry not a single pulse");
  property p_wakePulse;
    wakeTimerExpire |-> s_wakePulse;
  endproperty
  a_wakePulse: assert property (p_wakePulse)
    else $error("wake expiry not a single pulse");
  // reset must not disable its own check
  property p_resetValues;
    disable iff (1'b0) !rstn |=> noAckRequest && maxRetransmissions == 4'h0
      && backoffRandom == 16'hFF00 && ccaBitPeriods == 10'h040;
  endproperty
  a_resetValues: assert property (p_resetValues)
    else $error("bad value after reset");
  property p_ccaLegal;
    ccaBitPeriods == 10'h040 || ccaBitPeriods == 10'h080
      || ccaBitPeriods == 10'h100 || ccaBitPeriods == 10'h200;
  endproperty
  a_ccaLegal: assert property (p_ccaLegal)
    else $error("cca length not a legal step");
  property p_step;
    backoffStep |=> backoffRandom == (($past(backoffRandom) >> 1)
      ^ ($past(backoffRandom[0]) ? 16'hB400 : 16'h0000));
  endproperty
  a_step: assert property (p_step)
    else $error("generator step wrong");
  property p_rxEndStops;
    rxEnd && !rxStart |=> !rxTimeoutRunning;
  endproperty
  a_rxEndStops: assert property (p_rxEndStops)
    else $error("rx timer kept running after stop");
  property p_sleepEndStops;
    sleepEnd && !sleepStart && !wakeTimerReloadCommand && !syncDetected
      |=> !wakeTimerRunning;
  endproperty
  a_sleepEndStops: assert property (p_sleepEndStops)
    else $error("wake timer kept running after stop");
  // one masked indicator is enough in or mode
  property p_orStop;
    rxTimeoutRunning && qualityOrSelect && carrierSenseMask && carrierSense
      && !rxStart |-> ##[1:2] !rxTimeoutRunning;
  endproperty
  a_orStop: assert property (p_orStop)
    else $error("qualifier did not stop rx timer");
  // miso enable follows select one cycle late
  property p_misoOe;
    spiMisoOe == !$past(spiCsN);
  endproperty
  a_misoOe: assert property (p_misoOe)
    else $error("miso enable not following select");
endmodule // ptcsm_monitor

bind ptcsm_regbank ptcsm_monitor i_ptcsm_monitor (.ref_clk, .rstn,
  .spiCsN, .spiMisoOe,
  .rxStart, .rxEnd, .sleepStart, .sleepEnd, .syncDetected,
  .wakeTimerReloadCommand, .backoffStep, .carrierSense, .carrierSenseMask,
  .qualityOrSelect, .noAckRequest, .maxRetransmissions, .backoffRandom,
  .ccaBitPeriods, .rxTimeoutRunning, .rxTimeoutExpire, .wakeTimerRunning,
  .wakeTimerExpire);

// [sim/ptcsm_host.sv]
/* host side of the serial port: one mode 0 access per call.
   assumes ref_clk is the device clock; each sclk level lasts 4 cycles. */
`timescale 1ns/10ps
module ptcsm_host (
  // clock
  input wire ref_clk,
  // serial port
  output reg spiCsN,
  output reg spiSclk,
  output reg spiMosi,
  input wire spiMiso
);
  integer i;
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiMosi = 1'b0;
  end
  // header, address and one data byte; last byte in comes back in rd
  task xfer(input [7:0] hdr, input [7:0] adr, input [7:0] wd,
    output [7:0] rd);
    reg [23:0] sh;
    begin
      sh = {hdr, adr, wd};
      @(negedge ref_clk) spiCsN = 1'b0;
      repeat (4) @(negedge ref_clk);
      for (i = 0; i < 24; i = i + 1) begin
        spiMosi = sh[23 - i]; // msb first, set while clock low
        repeat (4) @(negedge ref_clk);
        rd = {rd[6:0], spiMiso};
        spiSclk = 1'b1;
        repeat (4) @(negedge ref_clk);
        spiSclk = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      spiCsN = 1'b1;
      spiMosi = ~spiMosi; // no stale level left on a released line
    end
  endtask
endmodule // ptcsm_host

// [sim/ptcsm_regbank_tb.sv]
/* self-checking bench for the protocol timer and csma bank.
   assumes the host model drives the port; clock period 100 ns. */
`timescale 1ns/10ps
module ptcsm_regbank_tb;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg [6:0] ev = 7'h00; // event pulses, one bit per protocol input
  reg carrierSense = 1'b0;
  reg syncQualityIndicator = 1'b0;
  reg preambleQualityIndicator = 1'b0;
  reg carrierSenseMask = 1'b0;
  reg syncQualityMask = 1'b0;
  reg preambleQualityMask = 1'b0;
  reg qualityOrSelect = 1'b0;
  wire spiCsN, spiSclk, spiMosi, spiMiso, spiMisoOe, noAckRequest;
  wire sleepReloadOnSyncWord, ackPayloadCarry, carrierSenseAccessEnable;
  wire carrierSensePersistent, autoFilterEnable;
  wire [3:0] maxRetransmissions, listenLength;
  wire [5:0] backoffUnitPrescale;
  wire [9:0] ccaBitPeriods;
  wire [2:0] maxBackoffCycles;
  wire [15:0] backoffRandom;
  wire rxTimeoutRunning, rxTimeoutExpire, wakeTimerRunning, wakeTimerExpire;
  wire [22:0] fieldsOut = {sleepReloadOnSyncWord, ackPayloadCarry,
    carrierSenseAccessEnable, carrierSensePersistent, autoFilterEnable,
    noAckRequest, maxRetransmissions, backoffUnitPrescale, listenLength,
    maxBackoffCycles};
  integer failures = 0;
  integer n_tests = 0;
  integer k, n;
  reg [7:0] rd;
  localparam [95:0] AD = 96'h51_52_53_54_55_56_57_58_64_65_66_67;
  localparam [95:0] RV = 96'h00_08_01_00_01_00_01_00_FF_00_04_00;
  localparam [95:0] FV = 96'hCF_FF_FF_FF_FF_FF_FF_FF_FF_FF_FF_F7;
  ptcsm_regbank i_ptcsm_regbank (.*, .syncDetected(ev[0]),
    .wakeTimerReloadCommand(ev[1]), .rxStart(ev[2]), .rxEnd(ev[3]),
    .sleepStart(ev[4]), .sleepEnd(ev[5]), .backoffStep(ev[6]));
  ptcsm_host i_ptcsm_host (.*);
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [23:0] got, input [23:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    i_ptcsm_host.xfer(8'h00, a, d, rd);
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      i_ptcsm_host.xfer(8'h01, a, 8'h00, rd);
      chk({16'h0000, rd}, {16'h0000, e});
    end
  endtask
  // one-cycle event, then one more cycle so its effect has landed
  task pulse(input integer b);
    begin
      ev[b] = 1'b1;
      @(negedge ref_clk) ev[b] = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  // cycles until an expiry, bounded so a dead timer cannot hang the run
  task cnt(input integer w);
    begin
      n = 0;
      while ((w ? wakeTimerExpire : rxTimeoutExpire) !== 1'b1 && n < 40) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      chk(n < 40, 24'h1);
      if (n >= 40)
        print_verdict;
    end
  endtask
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    for (k = 0; k < 12; k = k + 1) rdc(AD[95-8*k -: 8], RV[95-8*k -: 8]);
    for (k = 0; k < 12; k = k + 1) wr(AD[95-8*k -: 8], 8'hFF);
    for (k = 0; k < 12; k = k + 1) rdc(AD[95-8*k -: 8], FV[95-8*k -: 8]);
    chk({1'b0, fieldsOut}, 24'h7FFFFF);
    wr(8'h59, 8'hA5);
    rdc(8'h59, 8'h00);
    wr(8'h52, 8'h00);
    chk({noAckRequest, maxRetransmissions}, 24'h0);
    $display("register test done");
    for (k = 0; k < 4; k = k + 1) begin
      wr(8'h66, k[7:0]);
      chk(ccaBitPeriods, 24'h40 << k);
    end
    wr(8'h64, 8'h12);
    wr(8'h65, 8'h35);
    wr(8'h51, 8'h08);
    chk(backoffRandom, 24'h1235);
    pulse(6);
    chk(backoffRandom, 24'hBD1A);
    $display("csma test done");
    wr(8'h53, 8'h01);
    wr(8'h54, 8'h02);
    pulse(2);
    cnt(0);
    chk(n >= 10 && n <= 20, 24'h1);
    carrierSenseMask = 1'b1;
    qualityOrSelect = 1'b1;
    pulse(2);
    chk(rxTimeoutRunning, 24'h1);
    carrierSense = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(rxTimeoutRunning, 24'h0);
    qualityOrSelect = 1'b0;
    syncQualityMask = 1'b1;
    pulse(2);
    repeat (3) @(negedge ref_clk);
    chk(rxTimeoutRunning, 24'h1);
    pulse(3);
    chk(rxTimeoutRunning, 24'h0);
    $display("rx timer test done");
    wr(8'h57, 8'h01);
    wr(8'h58, 8'h03);
    wr(8'h56, 8'h00);
    wr(8'h51, 8'h80);
    pulse(0);
    chk(wakeTimerRunning, 24'h1);
    pulse(4);
    chk(wakeTimerRunning, 24'h0);
    pulse(1);
    chk(wakeTimerRunning, 24'h1);
    pulse(5);
    chk(wakeTimerRunning, 24'h0);
    pulse(1);
    cnt(1);
    chk(n >= 20 && n <= 30, 24'h1);
    $display("wake timer test done");
    print_verdict;
  end
endmodule // ptcsm_regbank_tb
